// File: ebd_defines.vh
`ifndef EBD_DEFINES_VH
`define EBD_DEFINES_VH

// Register byte offsets
`define EBD_OFS_IRQ_ENABLE 7'h00
`define EBD_OFS_IRQ_FLAGS 7'h04
`define EBD_OFS_CONTROL 7'h08
`define EBD_OFS_RX_END_LO 7'h0c
`define EBD_OFS_RX_END_HI 7'h10
`define EBD_OFS_SRC_START_LO 7'h14
`define EBD_OFS_SRC_START_HI 7'h18
`define EBD_OFS_SRC_END_LO 7'h1c
`define EBD_OFS_SRC_END_HI 7'h20
`define EBD_OFS_DEST_LO 7'h24
`define EBD_OFS_DEST_HI 7'h28
`define EBD_OFS_CSUM_LO 7'h2c
`define EBD_OFS_CSUM_HI 7'h30
`define EBD_OFS_RX_START_LO 7'h34
`define EBD_OFS_RX_START_HI 7'h38
`define EBD_OFS_MAC_LO 7'h3c
`define EBD_OFS_MAC_HI 7'h40

// Field positions
`define EBD_BIT_START_BUSY 5
`define EBD_BIT_CSUM_EN 4
`define EBD_BIT_TX_PENDING 3
`define EBD_BIT_DONE 5

// Widths and reset values
`define EBD_PTR_W 13
`define EBD_PTR_RESET 13'h0000
`define EBD_BYTE_RESET 8'h00
`define EBD_CSUM_RESET 16'h0000
`define EBD_PTR_TOP 13'h1fff

// Magic wake frame: sync bytes and address repeats
`define EBD_WAKE_SYNC_COUNT 3'h6
`define EBD_WAKE_REPEATS 5'h10

`endif

// File: ebd_dma.v
`timescale 1ns/1ps
`default_nettype none
`include "ebd_defines.vh"

module ebd_dma (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write
    input wire [6:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [6:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Buffer memory port, read data one cycle after address
    output reg [12:0] mem_addr,
    output reg mem_rd,
    output reg mem_wr,
    output reg [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    // Neighbouring engines, same clock
    input wire rx_store_req,
    input wire tx_done,
    // Receive byte stream for the wake filter, same clock
    input wire rx_frame_start,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_frame_end,
    // Results
    output reg dma_irq,
    output reg wake_match
);

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_WAIT_TX = 3'b010;
localparam ST_RUN = 3'b100;

reg [7:0] irq_enable_reg;
reg done_flag_reg;
reg start_busy_reg;
reg csum_en_reg;
reg tx_pending_reg;
reg [12:0] rx_end_reg, rx_start_reg, src_start_reg, src_end_reg, dest_reg;
reg [15:0] csum_result_reg;
reg [47:0] mac_reg;
reg [2:0] state_reg;
reg [12:0] isrc_reg, idst_reg;
reg [16:0] sum_reg;
reg odd_reg;
reg [7:0] hi_byte_reg;
reg last_reg;
reg rd_pend_reg;
reg byte_vld_reg, last_vld_reg;

// ---------------------------------------------------------------
// AXI write channel
// ---------------------------------------------------------------
reg [6:0] aw_addr_reg;
reg aw_have_reg, w_have_reg;
reg [31:0] w_data_reg;
reg [3:0] w_strb_reg;
wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
wire [7:0] wb = w_data_reg[7:0];
wire wb_en = w_strb_reg[0];

// Done event and folded sum from the engine; start from a control write
wire finishing;
wire [16:0] sum_fold;
wire dma_start = wr_go && wb_en && (aw_addr_reg >> 2) == (`EBD_OFS_CONTROL >> 2)
    && wb[`EBD_BIT_START_BUSY] && !start_busy_reg;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        aw_addr_reg <= 7'h00;
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
    end else begin
        s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
        s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= ((aw_addr_reg >> 2) > (`EBD_OFS_MAC_HI >> 2)) ? 2'b10 : 2'b00;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Register file; writes on the low byte lane, the MAC registers on the low three lanes
always @(posedge aclk) begin
    if (!aresetn) begin
        irq_enable_reg <= `EBD_BYTE_RESET;
        done_flag_reg <= 1'b0;
        start_busy_reg <= 1'b0;
        csum_en_reg <= 1'b0;
        tx_pending_reg <= 1'b0;
        rx_end_reg <= `EBD_PTR_RESET;
        rx_start_reg <= `EBD_PTR_RESET;
        src_start_reg <= `EBD_PTR_RESET;
        src_end_reg <= `EBD_PTR_RESET;
        dest_reg <= `EBD_PTR_RESET;
        csum_result_reg <= `EBD_CSUM_RESET;
        mac_reg <= 48'h000000000000;
    end else begin
        if (tx_done)
            tx_pending_reg <= 1'b0;
        if (wr_go && wb_en) begin
            case (aw_addr_reg >> 2)
                `EBD_OFS_IRQ_ENABLE >> 2: irq_enable_reg <= wb;
                `EBD_OFS_IRQ_FLAGS >> 2: done_flag_reg <= wb[`EBD_BIT_DONE];
                `EBD_OFS_CONTROL >> 2: begin
                    start_busy_reg <= wb[`EBD_BIT_START_BUSY];
                    csum_en_reg <= wb[`EBD_BIT_CSUM_EN];
                    if (wb[`EBD_BIT_TX_PENDING])
                        tx_pending_reg <= 1'b1;
                end
                `EBD_OFS_RX_END_LO >> 2: rx_end_reg[7:0] <= wb;
                `EBD_OFS_RX_END_HI >> 2: rx_end_reg[12:8] <= wb[4:0];
                `EBD_OFS_SRC_START_LO >> 2: src_start_reg[7:0] <= wb;
                `EBD_OFS_SRC_START_HI >> 2: src_start_reg[12:8] <= wb[4:0];
                `EBD_OFS_SRC_END_LO >> 2: src_end_reg[7:0] <= wb;
                `EBD_OFS_SRC_END_HI >> 2: src_end_reg[12:8] <= wb[4:0];
                `EBD_OFS_DEST_LO >> 2: dest_reg[7:0] <= wb;
                `EBD_OFS_DEST_HI >> 2: dest_reg[12:8] <= wb[4:0];
                `EBD_OFS_CSUM_LO >> 2: csum_result_reg[7:0] <= wb;
                `EBD_OFS_CSUM_HI >> 2: csum_result_reg[15:8] <= wb;
                `EBD_OFS_RX_START_LO >> 2: rx_start_reg[7:0] <= wb;
                `EBD_OFS_RX_START_HI >> 2: rx_start_reg[12:8] <= wb[4:0];
                `EBD_OFS_MAC_LO >> 2: mac_reg[23:0] <= w_data_reg[23:0];
                `EBD_OFS_MAC_HI >> 2: mac_reg[47:24] <= w_data_reg[23:0];
                default: ;
            endcase
        end
        // Hardware set beats a simultaneous firmware clear
        if (finishing) begin
            start_busy_reg <= 1'b0;
            done_flag_reg <= 1'b1;
            if (csum_en_reg)
                csum_result_reg <= ~(sum_fold[15:0]);
        end
    end
end

// ---------------------------------------------------------------
// AXI read channel
// ---------------------------------------------------------------
reg [7:0] rd_byte;
always @* begin
    rd_byte = 8'h00;
    case (s_axi_araddr >> 2)
        `EBD_OFS_IRQ_ENABLE >> 2: rd_byte = irq_enable_reg;
        `EBD_OFS_IRQ_FLAGS >> 2: rd_byte = {2'b00, done_flag_reg, 5'h00};
        `EBD_OFS_CONTROL >> 2: rd_byte = {2'b00, start_busy_reg, csum_en_reg,
            tx_pending_reg, 3'h0};
        `EBD_OFS_RX_END_LO >> 2: rd_byte = rx_end_reg[7:0];
        `EBD_OFS_RX_END_HI >> 2: rd_byte = {3'h0, rx_end_reg[12:8]};
        `EBD_OFS_SRC_START_LO >> 2: rd_byte = src_start_reg[7:0];
        `EBD_OFS_SRC_START_HI >> 2: rd_byte = {3'h0, src_start_reg[12:8]};
        `EBD_OFS_SRC_END_LO >> 2: rd_byte = src_end_reg[7:0];
        `EBD_OFS_SRC_END_HI >> 2: rd_byte = {3'h0, src_end_reg[12:8]};
        `EBD_OFS_DEST_LO >> 2: rd_byte = dest_reg[7:0];
        `EBD_OFS_DEST_HI >> 2: rd_byte = {3'h0, dest_reg[12:8]};
        `EBD_OFS_CSUM_LO >> 2: rd_byte = csum_result_reg[7:0];
        `EBD_OFS_CSUM_HI >> 2: rd_byte = csum_result_reg[15:8];
        `EBD_OFS_RX_START_LO >> 2: rd_byte = rx_start_reg[7:0];
        `EBD_OFS_RX_START_HI >> 2: rd_byte = {3'h0, rx_start_reg[12:8]};
        default: rd_byte = 8'h00;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'b00;
    end else begin
        s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if ((s_axi_araddr >> 2) == (`EBD_OFS_MAC_LO >> 2))
                s_axi_rdata <= {8'h00, mac_reg[23:0]};
            else if ((s_axi_araddr >> 2) == (`EBD_OFS_MAC_HI >> 2))
                s_axi_rdata <= {8'h00, mac_reg[47:24]};
            else
                s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= ((s_axi_araddr >> 2) > (`EBD_OFS_MAC_HI >> 2)) ? 2'b10 : 2'b00;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------
// DMA engine
// ---------------------------------------------------------------
// Read data stands the cycle after mem_rd, so a byte is used two cycles after its issue
wire byte_in = byte_vld_reg;
wire run_ok = state_reg == ST_RUN && start_busy_reg && !last_reg;
// A copy reads only while no byte waits, leaving the port free for its writes
wire issue = run_ok && !rx_store_req && (csum_en_reg || !byte_in);
assign finishing = byte_in && last_vld_reg && start_busy_reg;
wire [15:0] word_in = odd_reg ? {hi_byte_reg, mem_rdata} : 16'h0000;
wire [15:0] word_last = odd_reg ? {hi_byte_reg, mem_rdata} : {mem_rdata, 8'h00};
wire [16:0] sum_add = {1'b0, sum_reg[15:0]} + {16'h0000, sum_reg[16]} + {1'b0,
    (last_vld_reg ? word_last : word_in)};
assign sum_fold = {1'b0, sum_add[15:0]} + {16'h0000, sum_add[16]};

always @(posedge aclk) begin
    if (!aresetn) begin
        state_reg <= ST_IDLE;
        isrc_reg <= `EBD_PTR_RESET;
        idst_reg <= `EBD_PTR_RESET;
        sum_reg <= 17'h00000;
        odd_reg <= 1'b0;
        hi_byte_reg <= 8'h00;
        last_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        byte_vld_reg <= 1'b0;
        last_vld_reg <= 1'b0;
        mem_addr <= `EBD_PTR_RESET;
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        mem_wdata <= 8'h00;
        dma_irq <= 1'b0;
    end else begin
        dma_irq <= done_flag_reg && irq_enable_reg[`EBD_BIT_DONE];
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        rd_pend_reg <= 1'b0;
        byte_vld_reg <= rd_pend_reg;
        last_vld_reg <= last_reg;
        case (state_reg)
            ST_IDLE: begin
                if (dma_start) begin
                    isrc_reg <= src_start_reg;
                    idst_reg <= dest_reg;
                    sum_reg <= 17'h00000;
                    odd_reg <= 1'b0;
                    last_reg <= 1'b0;
                    state_reg <= (tx_pending_reg && !tx_done) ? ST_WAIT_TX : ST_RUN;
                end
            end
            ST_WAIT_TX: begin
                if (!start_busy_reg)
                    state_reg <= ST_IDLE;
                else if (!tx_pending_reg || tx_done)
                    state_reg <= ST_RUN;
            end
            ST_RUN: begin
                // Cancel leaves every register as it was
                if (!start_busy_reg) begin
                    state_reg <= ST_IDLE;
                end else begin
                    if (issue) begin
                        mem_addr <= isrc_reg;
                        mem_rd <= 1'b1;
                        rd_pend_reg <= 1'b1;
                        last_reg <= isrc_reg == src_end_reg;
                        if (isrc_reg == rx_end_reg)
                            isrc_reg <= rx_start_reg;
                        else
                            isrc_reg <= isrc_reg + 13'h0001;
                    end
                    if (byte_in) begin
                        if (csum_en_reg) begin
                            odd_reg <= !odd_reg;
                            hi_byte_reg <= mem_rdata;
                            sum_reg <= last_vld_reg ? sum_fold : sum_add;
                        end else begin
                            // Reading the next byte and writing this one share
                            // the port, so the write goes out when no read does
                            mem_wr <= 1'b1;
                            mem_wdata <= mem_rdata;
                            mem_addr <= idst_reg;
                            idst_reg <= idst_reg + 13'h0001;
                        end
                    end
                    if (finishing)
                        state_reg <= ST_IDLE;
                end
            end
            default: state_reg <= ST_IDLE;
        endcase
    end
end

// ---------------------------------------------------------------
// Wake frame filter
// ---------------------------------------------------------------
reg [5:0] rx_pos_reg;
reg dst_ok_reg;
reg [2:0] sync_reg;
reg [4:0] rep_reg;
reg [2:0] bix_reg;
wire [7:0] mac_byte = mac_reg[8 * (3'h5 - bix_reg) +: 8];

always @(posedge aclk) begin
    if (!aresetn || rx_frame_start) begin
        rx_pos_reg <= 6'h00;
        dst_ok_reg <= 1'b1;
        sync_reg <= 3'h0;
        rep_reg <= 5'h00;
        bix_reg <= 3'h0;
        wake_match <= 1'b0;
    end else if (rx_byte_valid && !wake_match) begin
        if (rx_pos_reg < 6'h06) begin
            rx_pos_reg <= rx_pos_reg + 6'h01;
            if (rx_byte != mac_reg[8 * (3'h5 - rx_pos_reg[2:0]) +: 8])
                dst_ok_reg <= 1'b0;
        end else if (sync_reg != `EBD_WAKE_SYNC_COUNT) begin
            sync_reg <= (rx_byte == 8'hff) ? sync_reg + 3'h1 : 3'h0;
        end else if (rx_byte == mac_byte) begin
            if (bix_reg == 3'h5) begin
                bix_reg <= 3'h0;
                rep_reg <= rep_reg + 5'h01;
                if (rep_reg + 5'h01 == `EBD_WAKE_REPEATS)
                    wake_match <= dst_ok_reg;
            end else begin
                bix_reg <= bix_reg + 3'h1;
            end
        end else begin
            // An FFh before any address byte matches keeps the sync run alive
            sync_reg <= (rx_byte == 8'hff && bix_reg == 3'h0 && rep_reg == 5'h00)
                ? `EBD_WAKE_SYNC_COUNT : ((rx_byte == 8'hff) ? 3'h1 : 3'h0);
            bix_reg <= 3'h0;
            rep_reg <= 5'h00;
        end
    end else if (rx_frame_end) begin
        wake_match <= 1'b0;
    end
end

endmodule

`default_nettype wire

// File: ebd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Shared packet buffer, one-cycle read latency
// ------------------------------------------------
module ebd_mem_model (
    // Clock
    input wire logic aclk,
    // Engine port
    input wire logic [12:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:8191];

    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'h00;
        end
    end

    // Lines toggle when no read is answered, so a stale byte never looks valid
    always @(posedge aclk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_rd) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// File: ebd_dma_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Port checks
// ------------------------------------------------
module ebd_dma_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [6:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Buffer port
    input wire logic [12:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic rx_store_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_bad_aw;
        s_axi_awvalid && s_axi_awready && (s_axi_awaddr[6:2] > 5'h10);
    endsequence

    property p_b_ends; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_ends: assert property (p_b_ends) else $error("write response repeated");
    property p_r_ends; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_ends: assert property (p_r_ends) else $error("read response repeated");
    property p_rd_walk; s_ar_taken |=> s_axi_rvalid; endproperty
    a_rd_walk: assert property (p_rd_walk) else $error("read data late");
    property p_ar_cause; $rose(s_axi_arready) |-> $past(s_axi_arvalid); endproperty
    a_ar_cause: assert property (p_ar_cause) else $error("arready without request");
    property p_bad_wr; s_bad_aw |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == 2'b10); endproperty
    a_bad_wr: assert property (p_bad_wr) else $error("unmapped write not refused");
    property p_rx_yield; rx_store_req |=> !mem_rd; endproperty
    a_rx_yield: assert property (p_rx_yield) else $error("read during receive store");
    property p_dest_lin;
        mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) + 13'h1;
    endproperty
    a_dest_lin: assert property (p_dest_lin) else $error("destination not linear");
    property p_copy_data; mem_wr |-> mem_wdata == $past(mem_rdata); endproperty
    a_copy_data: assert property (p_copy_data) else $error("copied byte differs");
endmodule

bind ebd_dma ebd_dma_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .rx_store_req);
`default_nettype wire

// File: ebd_dma_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebd_defines.vh"
// ------------------------------------------------
// Bench
// ------------------------------------------------
module ebd_dma_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [6:0] s_axi_awaddr = 7'h00;
    logic [6:0] s_axi_araddr = 7'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rv;
    logic [12:0] mem_addr, da;
    logic [7:0] mem_wdata, mem_rdata;
    logic mem_rd, mem_wr, dma_irq, wake_match;
    logic rx_store_req = 1'b0;
    logic tx_done = 1'b0;
    logic rx_frame_start = 1'b0;
    logic rx_byte_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [1:0] rr;
    logic [7:0] cp_exp [0:3] = '{8'h33, 8'h44, 8'h11, 8'h22};
    int miscompares = 0;
    int total_checks = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int base;

    always #20 aclk = ~aclk;

    always @(posedge aclk) begin
        if (mem_wr === 1'b1) wr_cnt++;
        if (mem_rd === 1'b1) rd_cnt++;
    end

    ebd_dma u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .rx_store_req(rx_store_req),
        .tx_done(tx_done), .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte),
        .rx_frame_end(1'b0), .dma_irq(dma_irq), .wake_match(wake_match));

    ebd_mem_model u_mem (.aclk(aclk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Each channel is released only at the edge that takes it
    task automatic axi_wr(input logic [6:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        int n;
        aw = 0;
        w = 0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w) && n < 50) begin
            @(posedge aclk);
            n++;
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 50) miscompares++;
    endtask

    task automatic axi_rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_arready !== 1'b1 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 50) miscompares++;
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        axi_wr(a, d, rr);
        check("write response", {30'h0, rr}, 32'h0);
    endtask

    task automatic rd_chk(input string nm, input logic [6:0] a, input logic [31:0] exp);
        axi_rd(a, rv, rr);
        check(nm, rv, exp);
    endtask

    task automatic set_ptr(input logic [6:0] lo, input logic [12:0] v);
        wr(lo, {24'h0, v[7:0]});
        wr(lo + 7'h4, {27'h0, v[12:8]});
    endtask

    // Polls busy, then keeps the restart gap before the next start
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            axi_rd(`EBD_OFS_CONTROL, rv, rr);
            n++;
        end while (rv[5] !== 1'b0 && n < 300);
        if (n >= 300) miscompares++;
        repeat (5) @(posedge aclk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #800000;
        miscompares++;
        tally_and_finish;
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk("control reset", `EBD_OFS_CONTROL, 32'h0);
        rd_chk("checksum reset", `EBD_OFS_CSUM_HI, 32'h0);
        wr(`EBD_OFS_SRC_START_HI, 32'hff);
        rd_chk("pointer high", `EBD_OFS_SRC_START_HI, 32'h1f);
        axi_wr(7'h44, 32'h5a, rr);
        check("unmapped write", {30'h0, rr}, 32'h2);
        axi_rd(7'h44, rv, rr);
        check("unmapped read", {30'h0, rr}, 32'h2);
        $display("registers test done");
        u_mem.mem[16] = 8'h89;
        u_mem.mem[17] = 8'hab;
        u_mem.mem[18] = 8'hcd;
        set_ptr(`EBD_OFS_SRC_START_LO, 13'h0010);
        set_ptr(`EBD_OFS_SRC_END_LO, 13'h0012);
        wr(`EBD_OFS_IRQ_ENABLE, 32'h20);
        wr(`EBD_OFS_IRQ_FLAGS, 32'h0);
        base = wr_cnt;
        wr(`EBD_OFS_CONTROL, 32'h30);
        wait_done;
        rd_chk("sum low", `EBD_OFS_CSUM_LO, 32'h53);
        rd_chk("sum high", `EBD_OFS_CSUM_HI, 32'ha9);
        rd_chk("done flag", `EBD_OFS_IRQ_FLAGS, 32'h20);
        check("irq raised", {31'h0, dma_irq}, 32'h1);
        check("checksum writes", wr_cnt - base, 32'h0);
        rd_chk("start kept", `EBD_OFS_SRC_START_LO, 32'h10);
        $display("odd checksum test done");
        u_mem.mem[32] = 8'h11;
        u_mem.mem[33] = 8'h22;
        u_mem.mem[34] = 8'h33;
        u_mem.mem[35] = 8'h44;
        set_ptr(`EBD_OFS_RX_START_LO, 13'h0020);
        set_ptr(`EBD_OFS_RX_END_LO, 13'h0023);
        set_ptr(`EBD_OFS_SRC_START_LO, 13'h0022);
        set_ptr(`EBD_OFS_SRC_END_LO, 13'h0021);
        set_ptr(`EBD_OFS_DEST_LO, 13'h1ffe);
        wr(`EBD_OFS_IRQ_FLAGS, 32'h0);
        wr(`EBD_OFS_IRQ_ENABLE, 32'h0);
        check("irq cleared", {31'h0, dma_irq}, 32'h0);
        wr(`EBD_OFS_CONTROL, 32'h20);
        rx_store_req <= 1'b1;
        repeat (2) @(posedge aclk);
        rx_store_req <= 1'b0;
        wait_done;
        da = 13'h1ffe;
        for (int i = 0; i < 4; i++) begin
            check("copied byte", {24'h0, u_mem.mem[da]}, {24'h0, cp_exp[i]});
            da = da + 13'h1;
        end
        rd_chk("sum kept", `EBD_OFS_CSUM_LO, 32'h53);
        rd_chk("copy flag", `EBD_OFS_IRQ_FLAGS, 32'h20);
        check("irq masked", {31'h0, dma_irq}, 32'h0);
        rd_chk("dest kept", `EBD_OFS_DEST_LO, 32'hfe);
        $display("wrapping copy test done");
        u_mem.mem[48] = 8'h12;
        u_mem.mem[49] = 8'h34;
        set_ptr(`EBD_OFS_SRC_START_LO, 13'h0030);
        set_ptr(`EBD_OFS_SRC_END_LO, 13'h0031);
        wr(`EBD_OFS_CONTROL, 32'h08);
        base = rd_cnt;
        wr(`EBD_OFS_CONTROL, 32'h38);
        repeat (20) @(posedge aclk);
        check("reads while transmit", rd_cnt - base, 32'h0);
        rd_chk("busy while deferred", `EBD_OFS_CONTROL, 32'h38);
        tx_done <= 1'b1;
        @(posedge aclk);
        tx_done <= 1'b0;
        wait_done;
        rd_chk("even sum low", `EBD_OFS_CSUM_LO, 32'hcb);
        rd_chk("even sum high", `EBD_OFS_CSUM_HI, 32'hed);
        $display("deferred checksum test done");
        set_ptr(`EBD_OFS_SRC_START_LO, 13'h0100);
        set_ptr(`EBD_OFS_SRC_END_LO, 13'h01ff);
        set_ptr(`EBD_OFS_DEST_LO, 13'h1000);
        wr(`EBD_OFS_IRQ_FLAGS, 32'h0);
        wr(`EBD_OFS_CONTROL, 32'h20);
        wr(`EBD_OFS_CONTROL, 32'h00);
        repeat (5) @(posedge aclk);
        base = wr_cnt;
        repeat (10) @(posedge aclk);
        check("writes after cancel", wr_cnt - base, 32'h0);
        rd_chk("cancel busy", `EBD_OFS_CONTROL, 32'h0);
        rd_chk("cancel flag", `EBD_OFS_IRQ_FLAGS, 32'h0);
        rd_chk("cancel dest", `EBD_OFS_DEST_HI, 32'h10);
        rd_chk("cancel sum", `EBD_OFS_CSUM_HI, 32'hed);
        $display("cancel test done");
        rx_frame_start <= 1'b1;
        @(posedge aclk);
        rx_frame_start <= 1'b0;
        rx_byte_valid <= 1'b1;
        for (int i = 0; i < 108; i++) begin
            rx_byte <= (i > 5 && i < 12) ? 8'hff : 8'h00;
            @(posedge aclk);
        end
        rx_byte_valid <= 1'b0;
        @(posedge aclk);
        check("wake match", {31'h0, wake_match}, 32'h1);
        $display("wake test done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
